// ==== logic/banked_regs_pkg.sv ====
// Purpose: Shared constants for the mode-banked core register file.
// Assumes: Core pipeline on the same clock drives every request.
// Notes:   Physical slots 0..15 are the shared view, 16..30 the banked copies.
// Notes on behaviour
// RULE1: Storage is thirty-one 32-bit general registers plus six status registers.
// RULE2: Sixteen indices are visible at once and the mode picks the physical copy behind each.
// RULE3: Index fifteen is the program counter and reads as a source for pc-relative addressing.
// RULE4: Indices zero to seven map to one shared physical register in every mode.
// RULE5: Indices eight to fourteen resolve to a physical copy that depends on the mode.
// RULE6: Fast interrupt mode has private copies of indices eight to twelve.
// RULE7: Every exception mode has private copies of indices thirteen and fourteen.
// RULE8: One current status register is shared and each of five exception modes keeps a saved copy of it.
// RULE9: Seven modes exist and the mode changes by software write or by exception entry.
// RULE10: System mode is privileged but uses the user registers with no banked copies.
// RULE11: A subroutine call writes its return address into index fourteen.
// RULE12: Every mode except user is privileged.
// RULE13: Instructions are 32 bits in the wide state and 16 bits in the compact state.
// RULE14: Software keeps words on four-byte and halfwords on two-byte boundaries.
// RULE15: Fetch, decode and execute form the pipeline and execute reads and writes the file.
// RULE16: The banked copy follows the mode of the execute cycle and a mode change acts from the next access.
`default_nettype none
package banked_regs_pkg;
  localparam int unsigned XLEN        = 32;
  localparam int unsigned NUM_GPR     = 31;
  localparam int unsigned NUM_SAVED   = 5;
  localparam int unsigned IDX_W       = 4;
  localparam int unsigned PHYS_W      = 5;
  localparam int unsigned MODE_W      = 5;
  // Architectural index roles
  localparam logic [3:0] IDX_LAST_SHARED = 4'h7;
  localparam logic [3:0] IDX_FAST_FIRST  = 4'h8;
  localparam logic [3:0] IDX_FAST_LAST   = 4'hC;
  localparam logic [3:0] IDX_STACK       = 4'hD;
  localparam logic [3:0] IDX_LINK        = 4'hE;
  localparam logic [3:0] IDX_PC          = 4'hF;
  // Physical slot layout
  localparam logic [4:0] PHYS_FAST_BASE  = 5'h10;
  localparam logic [4:0] PHYS_BANK_BASE  = 5'h15;
  localparam logic [4:0] PHYS_PC         = 5'h0F;
  // Status field positions
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_COMPACT  = 5;
  localparam int unsigned ST_FAST_DIS = 6;
  localparam int unsigned ST_IRQ_DIS  = 7;
  // Mode encodings in the status mode field
  typedef enum logic [4:0] {
    MODE_USER            = 5'h10,
    FAST_INTERRUPT_MODE  = 5'h11,
    MODE_IRQ             = 5'h12,
    SUPERVISOR_MODE      = 5'h13,
    MODE_ABT             = 5'h17,
    UNDEFINED_INSTR_MODE = 5'h1B,
    MODE_SYS             = 5'h1F
  } mode_t;
  // Saved-status bank numbers
  localparam logic [2:0] BANK_SUPERVISOR = 3'h0;
  localparam logic [2:0] BANK_ABT        = 3'h1;
  localparam logic [2:0] BANK_UND        = 3'h2;
  localparam logic [2:0] BANK_IRQ        = 3'h3;
  localparam logic [2:0] BANK_FAST       = 3'h4;
  localparam logic [2:0] BANK_NONE = 3'h7;
  // Reset values and pc steps
  localparam logic [31:0] STATUS_RESET = 32'h000000D3;
  localparam logic [31:0] PC_RESET     = 32'h00000000;
  localparam logic [31:0] STEP_WIDE    = 32'h00000004;
  localparam logic [31:0] STEP_COMPACT = 32'h00000002;
endpackage : banked_regs_pkg
`default_nettype wire

// ==== logic/banked_cpu_register_file.sv ====
// Purpose: Mode-banked register file read and written by the execute stage.
// Assumes: Decode supplies indices a cycle early; all inputs are on clk_i.
// Notes:   Read data is registered, so it shows state before a same-cycle write.
`default_nettype none
module banked_cpu_register_file (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Read ports
  input  wire logic [3:0]  rd_a_idx_i,
  input  wire logic [3:0]  rd_b_idx_i,
  output logic      [31:0] rd_a_data_o,
  output logic      [31:0] rd_b_data_o,
  // Write port
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [31:0] wr_data_i,
  // Program counter step and subroutine call
  input  wire logic        pc_step_i,
  input  wire logic        call_i,
  input  wire logic [31:0] call_ret_i,
  // Status writes
  input  wire logic        status_wr_i,
  input  wire logic [31:0] status_data_i,
  input  wire logic        saved_wr_i,
  input  wire logic [31:0] saved_data_i,
  // Exception entry
  input  wire logic        exc_i,
  input  wire logic [4:0]  exc_mode_i,
  input  wire logic [31:0] exc_ret_i,
  // Status view
  output logic      [31:0] pc_o,
  output logic      [31:0] current_status_reg_o,
  output logic      [31:0] saved_status_reg_o,
  output logic             privileged_o,
  output logic             compact_o
);

  typedef struct packed {
    logic [30:0][31:0] gpr;    // [RULE1]
    logic [4:0][31:0]  saved;  // [RULE1]
    logic [31:0]       status; // [RULE1]
    logic [31:0]       rd_a;
    logic [31:0]       rd_b;
    logic [31:0]       saved_view;
    logic              priv;
    logic              compact;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Exception mode to saved-status bank; user and system have none
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      banked_regs_pkg::SUPERVISOR_MODE:      bank_of = banked_regs_pkg::BANK_SUPERVISOR;
      banked_regs_pkg::MODE_ABT:             bank_of = banked_regs_pkg::BANK_ABT;
      banked_regs_pkg::UNDEFINED_INSTR_MODE: bank_of = banked_regs_pkg::BANK_UND;
      banked_regs_pkg::MODE_IRQ:             bank_of = banked_regs_pkg::BANK_IRQ;
      banked_regs_pkg::FAST_INTERRUPT_MODE:  bank_of = banked_regs_pkg::BANK_FAST;
      default:                   bank_of = banked_regs_pkg::BANK_NONE; // [RULE10]
    endcase
  endfunction : bank_of

  // Only the seven defined encodings are accepted as a new mode
  function automatic logic mode_ok(input logic [4:0] m);
    case (m)
      banked_regs_pkg::MODE_USER, banked_regs_pkg::FAST_INTERRUPT_MODE, banked_regs_pkg::MODE_IRQ,
      banked_regs_pkg::SUPERVISOR_MODE, banked_regs_pkg::MODE_ABT, banked_regs_pkg::UNDEFINED_INSTR_MODE,
      banked_regs_pkg::MODE_SYS: mode_ok = 1'b1; // [RULE9]
      default:                   mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  // Visible index to physical slot under a given mode
  function automatic logic [4:0] phys(input logic [4:0] m, input logic [3:0] idx);
    logic [2:0] b;
    b = bank_of(m);
    if (idx <= banked_regs_pkg::IDX_LAST_SHARED || idx == banked_regs_pkg::IDX_PC) begin
      phys = {1'b0, idx}; // [RULE4] [RULE3]
    end else if (m == banked_regs_pkg::FAST_INTERRUPT_MODE && idx <= banked_regs_pkg::IDX_FAST_LAST) begin
      phys = banked_regs_pkg::PHYS_FAST_BASE + 5'({1'b0, idx - banked_regs_pkg::IDX_FAST_FIRST}); // [RULE6]
    end else if (idx >= banked_regs_pkg::IDX_STACK && b != banked_regs_pkg::BANK_NONE) begin
      phys = banked_regs_pkg::PHYS_BANK_BASE + {1'b0, b, 1'b0}
             + 5'({1'b0, idx - banked_regs_pkg::IDX_STACK}); // [RULE7] [RULE5]
    end else begin
      phys = {1'b0, idx}; // [RULE10]
    end
  endfunction : phys

  logic [4:0]  cur_mode;
  logic [31:0] pc_step;
  logic [31:0] pc_seen;
  assign cur_mode = st_r.status[banked_regs_pkg::ST_MODE_LSB +: banked_regs_pkg::MODE_W];
  // Step follows the instruction width of the current state
  assign pc_step  = st_r.status[banked_regs_pkg::ST_COMPACT] ? banked_regs_pkg::STEP_COMPACT
                                                             : banked_regs_pkg::STEP_WIDE; // [RULE13]
  // Pc as seen by execute is two instructions ahead of the one executing
  assign pc_seen  = st_r.gpr[banked_regs_pkg::PHYS_PC] + {pc_step[30:0], 1'b0}; // [RULE15] [RULE3]

  // Next-state: reads use the mode now in force, updates land at the edge
  always_comb begin
    logic [2:0] nb;
    logic [4:0] nm;
    nb = 3'h0;
    nm = 5'h00;
    st_nxt = st_r;
    // Registered reads resolve under the current mode
    st_nxt.rd_a = (rd_a_idx_i == banked_regs_pkg::IDX_PC) ? pc_seen
                  : st_r.gpr[phys(cur_mode, rd_a_idx_i)]; // [RULE2] [RULE16]
    st_nxt.rd_b = (rd_b_idx_i == banked_regs_pkg::IDX_PC) ? pc_seen
                  : st_r.gpr[phys(cur_mode, rd_b_idx_i)]; // [RULE2] [RULE16]
    // Pc advances unless written
    if (pc_step_i) begin
      st_nxt.gpr[banked_regs_pkg::PHYS_PC] = st_r.gpr[banked_regs_pkg::PHYS_PC] + pc_step;
    end
    if (wr_en_i) begin
      st_nxt.gpr[phys(cur_mode, wr_idx_i)] = wr_data_i; // [RULE5] [RULE15]
    end
    // Call link beats a plain write to the link index
    if (call_i) begin
      st_nxt.gpr[phys(cur_mode, banked_regs_pkg::IDX_LINK)] = call_ret_i; // [RULE11]
    end
    // Bad mode encodings keep the old mode so banking never points nowhere
    if (status_wr_i) begin
      st_nxt.status = status_data_i;
      if (!mode_ok(status_data_i[banked_regs_pkg::ST_MODE_LSB +: banked_regs_pkg::MODE_W])) begin
        st_nxt.status[banked_regs_pkg::ST_MODE_LSB +: banked_regs_pkg::MODE_W] = cur_mode;
      end
    end
    if (saved_wr_i && bank_of(cur_mode) != banked_regs_pkg::BANK_NONE) begin
      st_nxt.saved[bank_of(cur_mode)] = saved_data_i; // [RULE8]
    end
    // Exception entry wins over everything else in its cycle
    if (exc_i && bank_of(exc_mode_i) != banked_regs_pkg::BANK_NONE) begin
      nb = bank_of(exc_mode_i);
      st_nxt.saved[nb] = st_r.status; // [RULE8]
      st_nxt.gpr[phys(exc_mode_i, banked_regs_pkg::IDX_LINK)] = exc_ret_i; // [RULE7]
      st_nxt.status = st_r.status;
      st_nxt.status[banked_regs_pkg::ST_MODE_LSB +: banked_regs_pkg::MODE_W] = exc_mode_i; // [RULE9]
      st_nxt.status[banked_regs_pkg::ST_COMPACT] = 1'b0;
      st_nxt.status[banked_regs_pkg::ST_IRQ_DIS] = 1'b1;
      if (exc_mode_i == banked_regs_pkg::FAST_INTERRUPT_MODE) begin
        st_nxt.status[banked_regs_pkg::ST_FAST_DIS] = 1'b1;
      end
    end
    // Views of the status that will be in force
    nm = st_nxt.status[banked_regs_pkg::ST_MODE_LSB +: banked_regs_pkg::MODE_W];
    st_nxt.priv = (nm != banked_regs_pkg::MODE_USER); // [RULE12]
    st_nxt.compact = st_nxt.status[banked_regs_pkg::ST_COMPACT]; // [RULE13]
    st_nxt.saved_view = (bank_of(nm) == banked_regs_pkg::BANK_NONE) ? 32'h00000000
                        : st_nxt.saved[bank_of(nm)];
  end

  // State register; frozen while the enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r        <= '0;
      st_r.status <= banked_regs_pkg::STATUS_RESET;
      st_r.priv   <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign rd_a_data_o          = st_r.rd_a;
  assign rd_b_data_o          = st_r.rd_b;
  assign pc_o                 = st_r.gpr[banked_regs_pkg::PHYS_PC];
  assign current_status_reg_o = st_r.status;
  assign saved_status_reg_o   = st_r.saved_view;
  assign privileged_o         = st_r.priv;
  assign compact_o            = st_r.compact;

  // Assertions
  logic quiet;
  assign quiet = ce_i && !exc_i && !status_wr_i;

  sequence s_exc_entry;
    ce_i && exc_i && bank_of(exc_mode_i) != banked_regs_pkg::BANK_NONE;
  endsequence

  a_pc_wide_step: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE13]
    quiet && pc_step_i && !compact_o && !(wr_en_i && wr_idx_i == banked_regs_pkg::IDX_PC)
    |=> pc_o == $past(pc_o) + 32'h00000004) else $error("wide pc step wrong");
  a_pc_read_ahead: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE3]
    ce_i && rd_a_idx_i == banked_regs_pkg::IDX_PC
    |=> rd_a_data_o == $past(pc_o) + ($past(compact_o) ? 32'h00000004 : 32'h00000008))
    else $error("pc read offset wrong");
  a_exc_saves_status: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
    s_exc_entry |=> saved_status_reg_o == $past(current_status_reg_o)) else $error("status not saved");
  a_exc_sets_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
    s_exc_entry |=> current_status_reg_o[4:0] == $past(exc_mode_i) && privileged_o)
    else $error("exception mode not entered");
  a_priv_tracks_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE12]
    privileged_o == (current_status_reg_o[4:0] != banked_regs_pkg::MODE_USER)) else $error("privilege wrong");
  a_call_links: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE11]
    ce_i && call_i && !exc_i && !status_wr_i ##1 ce_i && rd_a_idx_i == banked_regs_pkg::IDX_LINK && quiet
    |=> rd_a_data_o == $past(call_ret_i, 2)) else $error("return address lost");
  a_shared_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4]
    ce_i && wr_en_i && wr_idx_i <= 4'h7
    |=> st_r.gpr[$past(wr_idx_i)] == $past(wr_data_i)) else $error("shared register not written");
  a_fast_private: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
    ce_i && wr_en_i && cur_mode == banked_regs_pkg::FAST_INTERRUPT_MODE && wr_idx_i == 4'h8
    |=> st_r.gpr[8] == $past(st_r.gpr[8]) && st_r.gpr[16] == $past(wr_data_i))
    else $error("fast bank leaked");
  a_sys_unbanked: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    ce_i && wr_en_i && !call_i && cur_mode == banked_regs_pkg::MODE_SYS && wr_idx_i == 4'hD
    |=> st_r.gpr[13] == $past(wr_data_i)) else $error("system mode banked");

  // Link read in the cycle right after entry must see the handler's copy
  sequence s_link_read;
    quiet && rd_a_idx_i == banked_regs_pkg::IDX_LINK;
  endsequence

  a_exc_links: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE7]
    s_exc_entry ##1 s_link_read |=> rd_a_data_o == $past(exc_ret_i, 2)) else $error("exception link lost");
  // Supervisor stack reads come from its own slot, not the shared one
  a_super_stack: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
    ce_i && cur_mode == banked_regs_pkg::SUPERVISOR_MODE && rd_b_idx_i == banked_regs_pkg::IDX_STACK
    |=> rd_b_data_o == $past(st_r.gpr[banked_regs_pkg::PHYS_BANK_BASE])) else $error("supervisor stack shared");

endmodule : banked_cpu_register_file
`default_nettype wire

// ==== dv/pipe_model.sv ====
// Purpose: Execute-stage issue model feeding enable and pc steps.
// Assumes: Decode runs one cycle ahead of execute.
// Notes:   A stall drops the enable, freezing the whole stage.
`default_nettype none
module pipe_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Bench control
  input  wire logic run_i,
  input  wire logic stall_i,
  // To execute stage
  output logic      ce_o,
  output logic      pc_step_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Decode hands one issue slot per cycle to execute
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ce_o      <= 1'b1;
      pc_step_o <= 1'b0;
    end else begin
      ce_o      <= !stall_i;
      pc_step_o <= run_i;
    end
  end
endmodule : pipe_model
`default_nettype wire

// ==== dv/test_banked_cpu_register_file.sv ====
// Purpose: Self-checking bench for the banked register file.
// Assumes: Requests issued by NBA at rising edges, checked 1 ns later.
// Notes:   Rows write then read back, so aliasing shows up as overwrites.
`default_nettype none
module test_banked_cpu_register_file;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] m_usr = 5'h10, m_fast = 5'h11, m_irq = 5'h12, m_sup = 5'h13;
  localparam logic [4:0] m_abt = 5'h17, m_und = 5'h1B, m_sys = 5'h1F;
  localparam logic [4:0] op_wr = 5'h01, op_call = 5'h02, op_st = 5'h04, op_sav = 5'h08, op_exc = 5'h10;
  typedef struct {logic [4:0] m; logic [3:0] i; logic [31:0] w; logic [31:0] e;} row_t;
  logic        clk_i, rst_n_i, run, stall, wr_en, call, st_wr, sav_wr, exc;
  logic [3:0]  idx;
  logic [4:0]  exc_mode;
  logic [31:0] d, rd_a, rd_b, pc, cur_st, sav_st;
  wire         ce, pc_step;
  logic        priv, compact;
  int          error_cnt, tests_run, cycles;
  row_t        rows [15] = '{
    '{m_usr, 4'h3, 32'h11, 32'h22}, '{m_fast, 4'h3, 32'h22, 32'h22},
    '{m_usr, 4'h8, 32'h80, 32'h80}, '{m_fast, 4'h8, 32'h88, 32'h88},
    '{m_usr, 4'hC, 32'hC1, 32'hC0}, '{m_irq, 4'hC, 32'hC0, 32'hC0},
    '{m_usr, 4'hD, 32'hD0, 32'hD5}, '{m_sup, 4'hD, 32'hD1, 32'hD1},
    '{m_abt, 4'hD, 32'hD2, 32'hD2}, '{m_und, 4'hD, 32'hD3, 32'hD3},
    '{m_irq, 4'hD, 32'hD4, 32'hD4}, '{m_fast, 4'hD, 32'hD6, 32'hD6},
    '{m_sys, 4'hD, 32'hD5, 32'hD5}, '{m_sup, 4'hE, 32'hE1, 32'hE1},
    '{m_fast, 4'hE, 32'hE6, 32'hE6}};
  pipe_model i_pipe (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .stall_i(stall), .ce_o(ce), .pc_step_o(pc_step));
  banked_cpu_register_file i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .rd_a_idx_i(idx), .rd_b_idx_i(idx),
    .rd_a_data_o(rd_a), .rd_b_data_o(rd_b), .wr_en_i(wr_en), .wr_idx_i(idx), .wr_data_i(d),
    .pc_step_i(pc_step), .call_i(call), .call_ret_i(d + 32'h4), .status_wr_i(st_wr), .status_data_i(d),
    .saved_wr_i(sav_wr), .saved_data_i(d), .exc_i(exc), .exc_mode_i(exc_mode), .exc_ret_i(d),
    .pc_o(pc), .current_status_reg_o(cur_st), .saved_status_reg_o(sav_st), .privileged_o(priv),
    .compact_o(compact));
  // Free-running 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One request cycle; strobes drop after the taking edge, outputs settle 1 ns later
  task automatic req(input logic [4:0] s, input logic [3:0] i, input logic [31:0] v, input logic [4:0] m);
    @(posedge clk_i);
    {exc, sav_wr, st_wr, call, wr_en} <= s;
    idx <= i;
    d <= v;
    exc_mode <= m;
    @(posedge clk_i);
    {exc, sav_wr, st_wr, call, wr_en} <= 5'h00;
    #1;
  endtask : req
  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    req(5'h00, i, 32'h0, 5'h00);
    chk(rd_a, e);
    chk(rd_b, e);
  endtask : rd
  task automatic set_mode(input logic [4:0] m);
    req(op_st, 4'h0, {24'h0, 3'b110, m}, 5'h00);
    chk(cur_st, {24'h0, 3'b110, m});
    chk(32'(priv), 32'(m != m_usr));
  endtask : set_mode
  task automatic pipe_run(input int n);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (n) @(posedge clk_i);
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : pipe_run
  // Main sequence: table first, then the awkward cases
  initial begin
    {run, stall, wr_en, call, st_wr, sav_wr, exc} = 7'h00;
    {idx, exc_mode, d} = 41'h0;
    rst_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[k]) begin
      set_mode(rows[k].m);
      req(op_wr, rows[k].i, rows[k].w, 5'h00);
    end
    foreach (rows[k]) begin
      set_mode(rows[k].m);
      rd(rows[k].i, rows[k].e);
    end
    $display("test rows done");
    set_mode(m_usr);
    req(op_st, 4'h8, 32'hD1, 5'h00);
    chk(rd_a, 32'h80);
    rd(4'h8, 32'h88);
    set_mode(m_usr);
    req(op_exc, 4'hE, 32'h1000, m_sup);
    chk(cur_st, 32'hD3);
    chk(sav_st, 32'hD0);
    rd(4'hE, 32'h1000);
    req(op_exc, 4'h0, 32'h2000, m_usr);
    chk(cur_st, 32'hD3);
    req(op_exc, 4'h0, 32'h3000, m_fast);
    chk(cur_st, 32'hD1);
    chk(sav_st, 32'hD3);
    req(op_call | op_wr, 4'hE, 32'h200, 5'h00);  // Aligned return address
    rd(4'hE, 32'h204);
    req(op_sav, 4'h0, 32'h55, 5'h00);
    chk(sav_st, 32'h55);
    set_mode(m_usr);
    req(op_sav, 4'h0, 32'h66, 5'h00);
    chk(sav_st, 32'h0);
    set_mode(m_fast);
    chk(sav_st, 32'h55);
    $display("test exceptions done");
    req(op_wr, 4'hF, 32'h100, 5'h00);
    pipe_run(5);
    chk(pc, 32'h114);
    rd(4'hF, 32'h11C);
    req(op_st, 4'h0, 32'hF3, 5'h00);
    chk(32'(compact), 32'h1);
    pipe_run(5);
    chk(pc, 32'h11E);
    rd(4'hF, 32'h122);
    @(posedge clk_i);
    stall <= 1'b1;
    repeat (2) @(posedge clk_i);
    req(op_wr, 4'h3, 32'hBAD, 5'h00);
    @(posedge clk_i);
    stall <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(4'h3, 32'h22);
    $display("test pc and stall done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(cur_st, 32'hD3);
    chk(pc, 32'h0);
    chk(sav_st, 32'h0);
    rst_n_i <= 1'b1;
    rd(4'h3, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule : test_banked_cpu_register_file
`default_nettype wire
